// ===== core/cpf_pkg.sv
/*
  Package for the chirp packet framer: register offsets, field positions,
  reset values, timing figures and shared types.
  Assumes a single 125 MHz core clock and a synchronous active-high reset.
*/
`default_nettype none
package cpf_pkg;
  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] MODEM_SETUP_ONE_OFS   = 8'h00;
  localparam logic [7:0] SYM_TIMEOUT_UPPER_OFS = 8'h04;
  localparam logic [7:0] PREAMBLE_OFS          = 8'h08;
  localparam logic [7:0] PAYLOAD_LEN_OFS       = 8'h0C;
  localparam logic [7:0] TRANSMIT_SETUP_OFS    = 8'h10;
  localparam logic [7:0] DWELL_OFS             = 8'h14;
  localparam logic [7:0] HOP_STATE_OFS         = 8'h18;
  localparam logic [7:0] IRQ_FLAGS_OFS         = 8'h1C;
  localparam logic [7:0] TIME_ON_AIR_OFS       = 8'h20;
  localparam logic [7:0] CONTROL_OFS           = 8'h24;
  // Field positions
  localparam int BW_LSB     = 4;  // modem_setup_one_reg[7:4] bandwidth code
  localparam int CR_LSB     = 1;  // modem_setup_one_reg[3:1] coding rate
  localparam int CRC_EN_BIT = 0;  // modem_setup_one_reg[0]
  localparam int SF_LSB     = 4;  // symbol_timeout_upper_reg[7:4]
  localparam int HDRLESS_BIT = 2; // symbol_timeout_upper_reg[2]
  localparam int SLOW_BIT    = 3; // symbol_timeout_upper_reg[3]
  localparam int HOP_EN_BIT  = 0; // transmit_setup_reg[0]
  localparam int IRQ_HOP_BIT = 0; // irq flags: next_hop_irq
  localparam int IRQ_CRC_BIT = 1; // irq flags: payload_check_fail_irq
  localparam int IRQ_HDR_BIT = 2; // irq flags: header check failed
  localparam int CRC_PRES_BIT = 6; // hop_state_reg[6]
  // Reset values
  localparam logic [15:0] PREAMBLE_RST = 16'h000C;
  localparam logic [15:0] PREAMBLE_MIN = 16'h0006;
  localparam logic [3:0]  SF_RST       = 4'h7;
  localparam logic [2:0]  CR_RST       = 3'h1;
  localparam logic [7:0]  PL_RST       = 8'h01;
  localparam logic [7:0]  DWELL_RST    = 8'h00;
  // Preamble overhead in quarter symbols: 4 fixed + 0.25 extra
  localparam int unsigned PRE_FIXED_SYMS = 4;
  localparam int unsigned PRE_QTR_OVHD   = 17;
  localparam int unsigned HDR_SYMS       = 8;
  localparam logic [2:0]  HDR_CR         = 3'h4;

  // Frame phases, Gray along idle-preamble-header-payload
  typedef enum logic [2:0] {
    CPF_IDLE     = 3'b000,
    CPF_PREAMBLE = 3'b001,
    CPF_HEADER   = 3'b011,
    CPF_PAYLOAD  = 3'b010,
    CPF_DONE     = 3'b110
  } cpf_phase_t;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cpf_bus_t;

  // Radio-side event strobes from the demodulator
  typedef struct packed {
    logic preamble_found;
    logic header_ok;
    logic header_bad;
    logic hdr_crc_present;
    logic payload_done;
    logic payload_crc_bad;
  } cpf_rx_ev_t;
endpackage
`default_nettype wire

// ===== core/cpf_framer.sv
/*
  Packet framing and hop sequencing for the chirp modem.
  Assumes the demodulator delivers one-cycle event strobes on core_clk and
  the symbol timebase is derived here from bandwidth and spreading factor.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
`default_nettype none
module cpf_framer
  import cpf_pkg::*;
#(
  parameter int BW_HZ_DEFAULT = 125000
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Register port
  input  wire cpf_bus_t    bus_req,
  output logic [31:0]      bus_rdata,
  // Frame control and demodulator events
  input  wire logic        tx_start,
  input  wire logic        rx_start,
  input  wire cpf_rx_ev_t  rx_ev,
  // Modem status outputs
  output cpf_phase_t       frame_phase,
  output logic             symbol_tick,
  output logic             next_hop_request,
  output logic [5:0]       current_hop_index,
  output logic             hop_irq_level
);

  // Whole module state
  typedef struct packed {
    logic [3:0]  bw_code;
    logic [2:0]  coding_rate_code;
    logic        payload_check_enable;
    logic [3:0]  spreading_factor;
    logic        headerless_select;
    logic        slow_rate_robustness;
    logic [15:0] preamble_symbol_count;
    logic [7:0]  payload_len;
    logic        hopping_enable;
    logic [7:0]  dwell_symbol_count;
    logic        received_check_present;
    logic [5:0]  hop_index;
    logic [2:0]  irq_flags;
    logic [31:0] rdata;
    cpf_phase_t  phase;
    logic        is_tx;
    logic        rx_locked;
    logic [23:0] chip_cnt;
    logic [18:0] qsym_cnt;
    logic [18:0] qsym_target;
    logic [7:0]  dwell_cnt;
    logic        tick;
    logic        hop_req;
  } cpf_state_t;

  cpf_state_t s_q, s_d;

  // Cycles per chip for a bandwidth code (0..9: 7.8 kHz .. 500 kHz)
  function automatic logic [15:0] cyc_per_chip(input logic [3:0] code);
    case (code)
      4'h0: cyc_per_chip = 16'(125000000 / 7800);
      4'h1: cyc_per_chip = 16'(125000000 / 10400);
      4'h2: cyc_per_chip = 16'(125000000 / 15600);
      4'h3: cyc_per_chip = 16'(125000000 / 20800);
      4'h4: cyc_per_chip = 16'(125000000 / 31250);
      4'h5: cyc_per_chip = 16'(125000000 / 41700);
      4'h6: cyc_per_chip = 16'(125000000 / 62500);
      4'h8: cyc_per_chip = 16'(125000000 / 250000);
      4'h9: cyc_per_chip = 16'(125000000 / 500000);
      default: cyc_per_chip = 16'(125000000 / BW_HZ_DEFAULT);
    endcase
  endfunction

  // Payload symbols: 8 + max(ceil(num/den)*(CR+4), 0)
  function automatic logic [17:0] payload_syms(
    input logic [7:0] pl, input logic [3:0] sf, input logic crc,
    input logic ih, input logic de, input logic [2:0] cr);
    int num;
    int den;
    int blocks;
    num = 8 * int'(pl) - 4 * int'(sf) + 28 + 16 * int'(crc)
          - 20 * int'(ih);
    den = 4 * (int'(sf) - 2 * int'(de));
    blocks = (num > 0 && den > 0) ? (num + den - 1) / den : 0;
    payload_syms = 18'(8 + blocks * (int'(cr) + 4));
  endfunction

  logic [17:0] pay_syms;
  logic        crc_in_frame;
  logic        hdr_wr_hit;

  // Payload length and check bit as seen by this end
  always_comb begin
    crc_in_frame = s_q.is_tx || s_q.headerless_select
                   ? s_q.payload_check_enable : s_q.received_check_present;
    pay_syms = payload_syms(s_q.payload_len, s_q.spreading_factor,
                            crc_in_frame, s_q.headerless_select,
                            s_q.slow_rate_robustness, s_q.coding_rate_code);
    hdr_wr_hit = bus_req.wr && bus_req.addr == IRQ_FLAGS_OFS;
  end

  // Next state: registers, symbol timebase, frame phases, hopping
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.hop_req = 1'b0;
    // Register writes; preamble setting clamps at its minimum
    if (bus_req.wr) begin
      if (bus_req.addr == MODEM_SETUP_ONE_OFS) begin
        s_d.bw_code = bus_req.wdata[BW_LSB +: 4];
        s_d.coding_rate_code = bus_req.wdata[CR_LSB +: 3];
        s_d.payload_check_enable = bus_req.wdata[CRC_EN_BIT];
      end else if (bus_req.addr == SYM_TIMEOUT_UPPER_OFS) begin
        s_d.spreading_factor = bus_req.wdata[SF_LSB +: 4];
        s_d.headerless_select = bus_req.wdata[HDRLESS_BIT];
        s_d.slow_rate_robustness = bus_req.wdata[SLOW_BIT];
      end else if (bus_req.addr == PREAMBLE_OFS) begin
        s_d.preamble_symbol_count = bus_req.wdata[15:0] < PREAMBLE_MIN
                                    ? PREAMBLE_MIN : bus_req.wdata[15:0];
      end else if (bus_req.addr == PAYLOAD_LEN_OFS) begin
        s_d.payload_len = bus_req.wdata[7:0];
      end else if (bus_req.addr == TRANSMIT_SETUP_OFS) begin
        s_d.hopping_enable = bus_req.wdata[HOP_EN_BIT];
      end else if (bus_req.addr == DWELL_OFS) begin
        s_d.dwell_symbol_count = bus_req.wdata[7:0];
      end
    end
    if (hdr_wr_hit)
      s_d.irq_flags = s_q.irq_flags & ~bus_req.wdata[2:0];
    // chip counter, 2^SF chips per symbol, quarter-symbol ticks
    if (s_q.phase != CPF_IDLE) begin
      // Shift in 32 bits: the slowest bandwidth at SF 12 overflows 24
      if (s_q.chip_cnt == 24'(({16'h0000, cyc_per_chip(s_q.bw_code)}
                               << s_q.spreading_factor) >> 2) - 24'h1) begin
        s_d.chip_cnt = '0;
        s_d.tick = 1'b1;
        s_d.qsym_cnt = s_q.qsym_cnt + 19'h1;
      end else begin
        s_d.chip_cnt = s_q.chip_cnt + 24'h1;
      end
    end
    // dwell counted in whole symbols during payload
    if (s_q.tick && s_q.qsym_cnt[1:0] == 2'b00 && s_q.hopping_enable
        && s_q.phase == CPF_PAYLOAD && s_q.dwell_symbol_count != 8'h00) begin
      if (s_q.dwell_cnt == s_q.dwell_symbol_count - 8'h1) begin
        s_d.dwell_cnt = 8'h00;
        s_d.hop_req = 1'b1;
        s_d.hop_index = s_q.hop_index + 6'h1;
        s_d.irq_flags[IRQ_HOP_BIT] = 1'b1;
      end else begin
        s_d.dwell_cnt = s_q.dwell_cnt + 8'h1;
      end
    end
    // Frame sequencing
    case (s_q.phase)
      CPF_IDLE: begin
        if (tx_start || rx_start) begin
          s_d.hop_index = 6'h00;
          s_d.dwell_cnt = 8'h00;
          s_d.qsym_cnt = '0;
          s_d.chip_cnt = '0;
          s_d.is_tx = tx_start;
          s_d.rx_locked = 1'b0;
          s_d.phase = CPF_PREAMBLE;
          s_d.qsym_target = 19'({3'b000, s_q.preamble_symbol_count} * 4
                                + PRE_QTR_OVHD);
        end
      end
      CPF_PREAMBLE: begin
        if (s_q.is_tx ? s_q.qsym_cnt >= s_q.qsym_target
                      : rx_ev.preamble_found) begin
          s_d.qsym_cnt = '0;
          s_d.phase = s_q.headerless_select ? CPF_PAYLOAD : CPF_HEADER;
          s_d.qsym_target = s_q.headerless_select ? 19'(pay_syms * 4)
                                                  : 19'(HDR_SYMS * 4);
        end
      end
      CPF_HEADER: begin
        // header at rate 4/8 and own check
        if (s_q.is_tx && s_q.qsym_cnt >= s_q.qsym_target) begin
          s_d.qsym_cnt = '0;
          s_d.phase = CPF_PAYLOAD;
          s_d.qsym_target = 19'(pay_syms * 4);
        end else if (!s_q.is_tx && rx_ev.header_bad) begin
          // back to channel 0, hunt again
          s_d.irq_flags[IRQ_HDR_BIT] = 1'b1;
          s_d.hop_index = 6'h00;
          s_d.dwell_cnt = 8'h00;
          s_d.phase = CPF_PREAMBLE;
        end else if (!s_q.is_tx && rx_ev.header_ok) begin
          s_d.received_check_present = rx_ev.hdr_crc_present;
          s_d.qsym_cnt = '0;
          s_d.phase = CPF_PAYLOAD;
        end
      end
      CPF_PAYLOAD: begin
        if (s_q.is_tx ? s_q.qsym_cnt >= s_q.qsym_target
                      : rx_ev.payload_done) begin
          s_d.phase = CPF_DONE;
          // failure only when a check ran
          if (!s_q.is_tx && rx_ev.payload_crc_bad && (s_q.headerless_select
              ? s_q.payload_check_enable : s_q.received_check_present))
            s_d.irq_flags[IRQ_CRC_BIT] = 1'b1;
          if (!s_q.is_tx && s_q.headerless_select)
            s_d.received_check_present = s_q.payload_check_enable;
        end
      end
      default: s_d.phase = CPF_IDLE;
    endcase
    // Read data, one cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (bus_req.rd) begin
      if (bus_req.addr == MODEM_SETUP_ONE_OFS)
        s_d.rdata = 32'({s_q.bw_code, s_q.coding_rate_code,
                         s_q.payload_check_enable});
      else if (bus_req.addr == SYM_TIMEOUT_UPPER_OFS)
        s_d.rdata = 32'({s_q.spreading_factor, s_q.slow_rate_robustness,
                         s_q.headerless_select, 2'b00});
      else if (bus_req.addr == PREAMBLE_OFS)
        s_d.rdata = 32'(s_q.preamble_symbol_count);
      else if (bus_req.addr == PAYLOAD_LEN_OFS)
        s_d.rdata = 32'(s_q.payload_len);
      else if (bus_req.addr == TRANSMIT_SETUP_OFS)
        s_d.rdata = 32'(s_q.hopping_enable);
      else if (bus_req.addr == DWELL_OFS)
        s_d.rdata = 32'(s_q.dwell_symbol_count);
      else if (bus_req.addr == HOP_STATE_OFS)
        s_d.rdata = 32'({s_q.received_check_present, s_q.hop_index});
      else if (bus_req.addr == IRQ_FLAGS_OFS)
        s_d.rdata = 32'(s_q.irq_flags);
      else if (bus_req.addr == TIME_ON_AIR_OFS)
        s_d.rdata = 32'(pay_syms);
      else if (bus_req.addr == CONTROL_OFS)
        s_d.rdata = 32'(s_q.phase);
    end
  end

  // State register; reset gives header mode and 12-symbol preamble
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.preamble_symbol_count <= PREAMBLE_RST;
      s_q.spreading_factor <= SF_RST;
      s_q.coding_rate_code <= CR_RST;
      s_q.payload_len <= PL_RST;
      s_q.dwell_symbol_count <= DWELL_RST;
      s_q.phase <= CPF_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign bus_rdata = s_q.rdata;
  assign frame_phase = s_q.phase;
  assign symbol_tick = s_q.tick;
  assign next_hop_request = s_q.hop_req;
  assign current_hop_index = s_q.hop_index;
  assign hop_irq_level = s_q.irq_flags[IRQ_HOP_BIT];

  // Assertions
  a_preamble_floor: assert property (@(posedge core_clk) disable iff (srst)
    s_q.preamble_symbol_count >= PREAMBLE_MIN)
    else $error("preamble setting below six");
  a_hop_sets_flag: assert property (@(posedge core_clk) disable iff (srst)
    next_hop_request |-> hop_irq_level)
    else $error("hop without flag");
  a_hop_counts: assert property (@(posedge core_clk) disable iff (srst)
    s_d.hop_req |=> current_hop_index == $past(current_hop_index) + 6'h1)
    else $error("hop index not incremented");
  a_no_hop_early: assert property (@(posedge core_clk) disable iff (srst)
    next_hop_request |-> $past(s_q.phase) == CPF_PAYLOAD)
    else $error("hop before payload");
  a_bad_hdr_chan0: assert property (@(posedge core_clk) disable iff (srst)
    (s_q.phase == CPF_HEADER && !s_q.is_tx && rx_ev.header_bad)
    |=> current_hop_index == 6'h00 && frame_phase == CPF_PREAMBLE)
    else $error("bad header did not restart");
  a_no_crc_no_fail: assert property (@(posedge core_clk) disable iff (srst)
    (s_q.phase == CPF_PAYLOAD && !s_q.headerless_select
     && !s_q.received_check_present) |=> !$rose(s_q.irq_flags[IRQ_CRC_BIT]))
    else $error("check failure without check");
  a_hdrless_skip: assert property (@(posedge core_clk) disable iff (srst)
    (s_q.phase == CPF_PREAMBLE && s_q.headerless_select)
    |=> frame_phase != CPF_HEADER)
    else $error("header sent in headerless mode");
  a_set_wins: assert property (@(posedge core_clk) disable iff (srst)
    (s_d.hop_req && hdr_wr_hit) |=> hop_irq_level)
    else $error("hop flag lost to clear");
  a_wr1_clear: assert property (@(posedge core_clk) disable iff (srst)
    (hdr_wr_hit && bus_req.wdata[0] && !s_d.hop_req) |=> !hop_irq_level)
    else $error("flag not cleared");
  c_tx_frame: cover property (@(posedge core_clk)
    s_q.is_tx && frame_phase == CPF_DONE);
  c_hop: cover property (@(posedge core_clk) next_hop_request);
  c_bad_hdr: cover property (@(posedge core_clk)
    s_q.irq_flags[IRQ_HDR_BIT]);
endmodule
`default_nettype wire

// ===== verification/cpf_remote_model.sv
/*
  Far-side demodulator model: turns bench commands into one-cycle event
  strobes toward the framer.
  Assumes its tasks are called from one bench process at a time.
*/
`default_nettype none
module cpf_remote_model
  import cpf_pkg::*;
(
  // Clock
  input  wire logic     core_clk,
  // Event strobes toward the framer
  output var cpf_rx_ev_t rx_ev
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strobes idle low, so a released line never reads as an event
  initial rx_ev = '0;

  // One strobe for one cycle, launched just after an edge
  task automatic pulse(input cpf_rx_ev_t ev);
    @(posedge core_clk);
    rx_ev <= ev;
    @(posedge core_clk);
    rx_ev <= '0;
  endtask

  // Remote shares preamble length and rate settings
  task automatic preamble();
    pulse(cpf_rx_ev_t'(6'h20));
  endtask

  // Header verdict; check presence only on a good header
  task automatic header(input logic good, input logic crc);
    pulse(cpf_rx_ev_t'({1'b0, good, !good, good & crc, 2'b00}));
  endtask

  // Payload end; a bad check only comes with done
  task automatic done(input logic bad);
    pulse(cpf_rx_ev_t'({4'h0, 1'b1, bad}));
  endtask
endmodule
`default_nettype wire

// ===== verification/cpf_framer_bench.sv
/*
  Self-checking bench for the chirp packet framer: register port tasks,
  frame and hop scenarios against a far-side demodulator model.
  Assumes a 125 MHz clock and bandwidth code 7 standing for 125 kHz.
*/
`default_nettype none
module cpf_framer_bench
  import cpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles per chip at 125 kHz; quarter and whole symbol at spread 6
  localparam longint CHIP_CYC = 64'd1000000000000 / 125000 / CLK_PERIOD_PS;
  localparam int     QTR6     = int'((CHIP_CYC << 6) / 4);
  localparam int     SYM6     = 4 * QTR6;
  // Rows: length, spread, check, headerless, slow, rate
  localparam int TBL [5][6] = '{'{1, 7, 0, 0, 0, 1}, '{255, 12, 1, 0, 1, 4},
    '{10, 6, 1, 1, 0, 2}, '{1, 12, 0, 1, 0, 3}, '{64, 9, 0, 0, 1, 4}};

  logic        core_clk, srst, tx_start, rx_start;
  cpf_bus_t    bus_req;
  logic [31:0] bus_rdata;
  cpf_rx_ev_t  rx_ev;
  cpf_phase_t  frame_phase;
  logic        symbol_tick, next_hop_request, hop_irq_level;
  logic [5:0]  current_hop_index;
  int          failures, n_compared, cyc, t, last;

  cpf_framer cpf_framer_inst (
    .core_clk(core_clk), .srst(srst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .tx_start(tx_start), .rx_start(rx_start),
    .rx_ev(rx_ev), .frame_phase(frame_phase), .symbol_tick(symbol_tick),
    .next_hop_request(next_hop_request),
    .current_hop_index(current_hop_index), .hop_irq_level(hop_irq_level));
  cpf_remote_model cpf_remote_model_inst (.core_clk(core_clk), .rx_ev(rx_ev));

  // Free-running core clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Hang guard; the hop dwell dominates the run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 100000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic phase_is(input string what, input cpf_phase_t p);
    chk(what, {29'h0, frame_phase}, {29'h0, p});
  endtask

  // One-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic expect_reg(input string what, input logic [7:0] a,
                            input logic [31:0] mask, exp);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 chk(what, bus_rdata & mask, exp);
  endtask

  task automatic start_frame(input logic tx);
    @(posedge core_clk);
    if (tx) tx_start <= 1'b1;
    else rx_start <= 1'b1;
    @(posedge core_clk);
    tx_start <= 1'b0;
    rx_start <= 1'b0;
    #1;
  endtask

  function automatic int airtime(int pl, sf, crc, ih, de, cr);
    int num, den, c;
    num = 8 * pl - 4 * sf + 28 + 16 * crc - 20 * ih;
    den = 4 * (sf - 2 * de);
    c = (num > 0) ? (num + den - 1) / den : 0;
    return 8 + c * (cr + 4);
  endfunction

  // Header-mode receive: a bad header first, then a good frame
  task automatic rx_header_frame(input logic own_en, crc_on, bad);
    bus_wr(MODEM_SETUP_ONE_OFS, {24'h0, 4'h7, 3'h1, own_en});
    bus_wr(IRQ_FLAGS_OFS, 32'h7);
    start_frame(1'b0);
    cpf_remote_model_inst.preamble();
    #1 phase_is("rx header", CPF_HEADER);
    cpf_remote_model_inst.header(1'b0, 1'b0);
    #1 phase_is("restart", CPF_PREAMBLE);
    chk("channel zero", {26'h0, current_hop_index}, 32'h0);
    expect_reg("hdr flag", IRQ_FLAGS_OFS, 32'h4, 32'h4);
    cpf_remote_model_inst.preamble();
    cpf_remote_model_inst.header(1'b1, crc_on);
    #1 phase_is("rx payload", CPF_PAYLOAD);
    cpf_remote_model_inst.done(bad);
    #1 phase_is("rx done", CPF_DONE);
    @(posedge core_clk);
    #1 phase_is("rx idle", CPF_IDLE);
    expect_reg("chk flag", IRQ_FLAGS_OFS, 32'h2,
               {30'h0, crc_on & bad, 1'b0});
    expect_reg("chk present", HOP_STATE_OFS, 32'h40,
               {25'h0, crc_on, 6'h0});
  endtask

  initial begin
    srst = 1'b1;
    tx_start = 1'b0;
    rx_start = 1'b0;
    bus_req = '0;
    failures = 0;
    n_compared = 0;
    cyc = 0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    bus_wr(PREAMBLE_OFS, 32'h3);
    expect_reg("pre floor", PREAMBLE_OFS, 32'hFFFF, 32'h6);
    bus_wr(PREAMBLE_OFS, 32'hFFFF);
    expect_reg("pre max", PREAMBLE_OFS, 32'hFFFF, 32'hFFFF);
    start_frame(1'b1);
    phase_is("tx preamble", CPF_PREAMBLE);
    chk("tx channel", {26'h0, current_hop_index}, 32'h0);
    // Reset in mid-frame must restore phase, preamble, spread, header mode, rate, check enable and hop enable defaults
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    #1 phase_is("reset idle", CPF_IDLE);
    expect_reg("pre reset", PREAMBLE_OFS, 32'hFFFF, 32'hC);
    expect_reg("hdr default", SYM_TIMEOUT_UPPER_OFS, 32'hF4, 32'h70);
    expect_reg("rate reset", MODEM_SETUP_ONE_OFS, 32'hF, 32'h2);
    expect_reg("hop off", TRANSMIT_SETUP_OFS, 32'h1, 32'h0);
    bus_wr(8'h40, 32'hFF);
    expect_reg("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    bus_wr(HOP_STATE_OFS, 32'h3F);
    expect_reg("index ro", HOP_STATE_OFS, 32'h3F, 32'h0);
    // Airtime table; idle receiver in header mode counts the received
    // check bit, still clear after reset, not its own enable
    for (int i = 0; i < 5; i++) begin
      bus_wr(MODEM_SETUP_ONE_OFS, 32'(112 | (TBL[i][5] << 1) | TBL[i][2]));
      bus_wr(SYM_TIMEOUT_UPPER_OFS,
             32'((TBL[i][1] << 4) | (TBL[i][4] << 3) | (TBL[i][3] << 2)));
      bus_wr(PAYLOAD_LEN_OFS, 32'(TBL[i][0]));
      expect_reg("airtime", TIME_ON_AIR_OFS, 32'hFFFF, 32'(airtime(TBL[i][0],
        TBL[i][1], TBL[i][3] ? TBL[i][2] : 0, TBL[i][3], TBL[i][4],
        TBL[i][5])));
    end
    // Headerless hop at spread 6, one symbol dwell
    bus_wr(SYM_TIMEOUT_UPPER_OFS, 32'h64);
    bus_wr(TRANSMIT_SETUP_OFS, 32'h1);
    bus_wr(DWELL_OFS, 32'h1);
    start_frame(1'b0);
    cpf_remote_model_inst.preamble();
    #1 phase_is("no header", CPF_PAYLOAD);
    t = 0;
    last = -1;
    while (next_hop_request !== 1'b1 && t < 2 * SYM6) begin
      @(posedge core_clk);
      #1 t++;
      if (symbol_tick === 1'b1 && last >= 0) chk("tick gap", t - last, QTR6);
      if (symbol_tick === 1'b1) last = t;
    end
    chk("dwell", 32'(t >= SYM6 - QTR6 && t <= SYM6 + QTR6), 32'h1);
    @(posedge core_clk);
    #1 chk("hop index", {26'h0, current_hop_index}, 32'h1);
    chk("hop level", {31'h0, hop_irq_level}, 32'h1);
    expect_reg("index reg", HOP_STATE_OFS, 32'h3F, 32'h1);
    bus_wr(IRQ_FLAGS_OFS, 32'h0);
    expect_reg("hop kept", IRQ_FLAGS_OFS, 32'h1, 32'h1);
    bus_wr(IRQ_FLAGS_OFS, 32'h1);
    expect_reg("hop clear", IRQ_FLAGS_OFS, 32'h1, 32'h0);
    chk("level clear", {31'h0, hop_irq_level}, 32'h0);
    cpf_remote_model_inst.done(1'b0);
    #1 phase_is("hop done", CPF_DONE);
    // Header mode at spread 7; receiver's own enable must not matter
    bus_wr(SYM_TIMEOUT_UPPER_OFS, 32'h70);
    rx_header_frame(1'b0, 1'b1, 1'b1);
    rx_header_frame(1'b1, 1'b0, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
